// ==== src/packed_add_halve_carry_unit.sv ====
// Packed add, add-and-halve, add-with-carry and shift-append execution unit.
// Operation
// - Any halfword lane overflow in either quad add variant sets control bit 20.
// - Quad halfword add: four independent 16-bit lane sums fill all 64 bits.
// - Saturating quad halfword add packs four unsigned saturated sums into 64 bits.
// - Non-saturating halfword lanes keep sum modulo 65536, dropping carry out.
// - Saturating halfword lanes that overflow clamp to 0xffff.
// - Only reserved-instruction or extension-disabled exceptions; never data dependent.
// - Octal byte halve adds eight byte lanes into matching destination bytes.
// - Non-rounding halve outputs bits 8..1 of the 9-bit lane sum.
// - Rounding halve adds one to the 9-bit sum before taking bits 8..1.
// - Octal halve decodes as major 011111, function 010100, sub-op 11000 or 11010.
// - Quad byte halve uses low four lanes, sign-extends bit 7 of top byte.
// - Quad byte halve decodes as function 011000 with sub-op 00000 or 00010.
// - No add-and-halve variant alters the control register.
// - Word add carry sums signed low words plus control bit 13.
// - Word add carry sets bit 20 when sum bit 32 differs from bit 31.
// - Word add carry writes low 32 sum bits sign-extended to 64.
// - Word add carry decodes as major 011111, function 010000, sub-op 10001.
// - Shift append shifts target low word left, fills with source low bits, sign-extends.
// - Shift append decodes as function 110001, sub-op 00000, amount in rd field.
// - Zero shift amount writes target low word unchanged, sign-extended.
`timescale 1ns/10ps
module packed_add_halve_carry_unit
    import add_halve_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Issue from the pipeline.
    input wire logic issue_valid,
    input wire issue_s issue,
    input wire logic ext_enabled,
    // Software write of the control register by the pipeline.
    input wire logic ctrl_wr_en,
    input wire logic [31:0] ctrl_wr_data,
    // Results.
    output logic result_valid,
    output result_s result,
    output logic exc_reserved,
    output logic exc_disabled,
    output logic [31:0] dsp_control_reg
);

    // Decoder shared by the result path and the exception path.
    // Keeping it in one function means both paths always agree on what is legal.
    // Any encoding that falls through stays OP_NONE and is refused as reserved,
    // so a half-recognised word can never produce a partial result.
    function automatic op_e decode(input logic [31:0] ins);
        logic [5:0] fn;
        logic [4:0] so;
        fn = ins[FUNC_HI:FUNC_LO];
        so = ins[SUBOP_HI:SUBOP_LO];
        decode = OP_NONE;
        if (ins[MAJOR_HI:MAJOR_LO] == OP_EXT_MAJOR)
        begin
            unique case (fn)
                FN_OCT:
                begin
                    if (so == SO_QH_ADD)
                        decode = OP_QH_ADD;
                    else if (so == SO_QH_SAT)
                        decode = OP_QH_SAT;
                    else if (so == SO_OB_HALVE)
                        decode = OP_OB_HALVE;
                    else if (so == SO_OB_HALVE_R)
                        decode = OP_OB_HALVE_R;
                end
                FN_QUAD:
                begin
                    if (so == SO_QB_HALVE)
                        decode = OP_QB_HALVE;
                    else if (so == SO_QB_HALVE_R)
                        decode = OP_QB_HALVE_R;
                end
                FN_WORD:
                begin
                    if (so == SO_WORD_CARRY)
                        decode = OP_WORD_CARRY;
                end
                FN_APPEND:
                begin
                    if (so == SO_APPEND)
                        decode = OP_APPEND;
                end
                // Every other function code belongs to instructions this unit does not run.
                default:
                    decode = OP_NONE;
            endcase
        end
    endfunction

    // Decoded operation, operands and the shift amount pulled from the issue bundle.
    // The shift amount shares the destination field, so it is only meaningful
    // for shift append; other operations ignore it.
    op_e op;
    logic [31:0] ctrl_ff;
    logic [63:0] s_val;
    logic [63:0] t_val;
    logic [4:0] shamt;

    assign op = decode(issue.instr);
    assign s_val = issue.src_s;
    assign t_val = issue.src_t;
    assign shamt = issue.instr[RD_HI:RD_LO];
    assign dsp_control_reg = ctrl_ff;

    // Halfword lanes: wrap and saturate both come from one 17-bit sum per lane.
    // Sharing the adder keeps the two variants in step; the seventeenth bit is
    // both the wrap discard and the saturation trigger, and also feeds the flag.
    // Lanes are fully independent, so no carry ever crosses a lane boundary.
    logic [63:0] qh_wrap;
    logic [63:0] qh_sat;
    logic [3:0] qh_ovf;
    genvar h;
    generate
        for (h = 0; h < 4; h++)
        begin : g_half
            logic [16:0] sum;
            assign sum = {1'b0, s_val[16*h +: 16]} + {1'b0, t_val[16*h +: 16]};
            assign qh_ovf[h] = sum[16];
            assign qh_wrap[16*h +: 16] = sum[15:0];
            assign qh_sat[16*h +: 16] = sum[16] ? 16'hffff : sum[15:0];
        end
    endgenerate

    // Byte halve lanes; the rounding one is a carry-in so each lane stays 9 bits wide.
    // The ninth bit is kept as the top of the halved byte, so these lanes never
    // overflow and never touch the control register.
    // The quad forms reuse the low four lanes rather than a second adder set.
    logic [63:0] ob_trunc;
    logic [63:0] ob_round;
    genvar b;
    generate
        for (b = 0; b < 8; b++)
        begin : g_byte
            logic [8:0] sum_t;
            logic [8:0] sum_r;
            assign sum_t = {1'b0, s_val[8*b +: 8]} + {1'b0, t_val[8*b +: 8]};
            assign sum_r = sum_t + 9'h001;
            assign ob_trunc[8*b +: 8] = sum_t[8:1];
            assign ob_round[8*b +: 8] = sum_r[8:1];
        end
    endgenerate

    // Word add with carry: 33-bit signed sum, overflow when the top two bits differ.
    // The carry comes from the register as it stands, not from a write that lands
    // at the same edge, so a pipeline that wants a fresh carry must write it first.
    logic [32:0] wsum;
    logic wc_ovf;
    assign wsum = {s_val[31], s_val[31:0]} + {t_val[31], t_val[31:0]}
                + {32'h0000_0000, ctrl_ff[CARRY_BIT]};
    assign wc_ovf = wsum[32] ^ wsum[31];

    // Shift append: the target word moves up and the freed low bits take the
    // same number of low bits of the source, picked out by a mask.
    // The mask is empty for a zero amount, so the target word passes untouched.
    logic [31:0] app_mask;
    logic [31:0] app_word;
    assign app_mask = ~(32'hffff_ffff << shamt);
    assign app_word = (shamt == 5'h00) ? t_val[31:0]
                    : ((t_val[31:0] << shamt) | (s_val[31:0] & app_mask));

    // Result selection and destination choice.
    // Data and flag default to zero (dest to the rd field) so an unrecognised word leaves no stale data
    // and no flag request behind; only the two quad adds and the word add may
    // ask for the overflow flag.
    logic [63:0] nxt_data;
    logic nxt_ouflag;
    logic [4:0] nxt_dest;
    logic [31:0] qb_low;
    always_comb
    begin
        nxt_data = 64'h0;
        nxt_ouflag = 1'b0;
        nxt_dest = issue.instr[RD_HI:RD_LO];
        qb_low = 32'h0;
        unique case (op)
            OP_QH_ADD:
            begin
                nxt_data = qh_wrap;
                nxt_ouflag = |qh_ovf;
            end
            OP_QH_SAT:
            begin
                nxt_data = qh_sat;
                nxt_ouflag = |qh_ovf;
            end
            OP_OB_HALVE:
            begin
                nxt_data = ob_trunc;
            end
            OP_OB_HALVE_R:
            begin
                nxt_data = ob_round;
            end
            OP_QB_HALVE:
            begin
                qb_low = ob_trunc[31:0];
                nxt_data = {{32{qb_low[31]}}, qb_low};
            end
            OP_QB_HALVE_R:
            begin
                qb_low = ob_round[31:0];
                nxt_data = {{32{qb_low[31]}}, qb_low};
            end
            OP_WORD_CARRY:
            begin
                nxt_data = {{32{wsum[31]}}, wsum[31:0]};
                nxt_ouflag = wc_ovf;
            end
            OP_APPEND:
            begin
                nxt_data = {{32{app_word[31]}}, app_word};
                nxt_dest = issue.instr[RT_HI:RT_LO];
            end
            OP_NONE:
            begin
                nxt_data = 64'h0;
            end
        endcase
    end

    // An issue is taken only when it is valid, the extension is on and it decodes.
    // Refused issues still answer, but through the exception outputs alone.
    logic accept;
    assign accept = issue_valid && ext_enabled && (op != OP_NONE);

    // Control register: software writes first, then the unit may only OR in the flag.
    // Setting after the software write means a same-cycle overflow is never lost.
    // Only the flag bit is ever ORed in, so every other field keeps whatever
    // software last wrote; the unit itself can never clear anything.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_ff <= CTRL_RESET;
        else
        begin
            if (ctrl_wr_en)
                ctrl_ff <= ctrl_wr_data;
            if (accept && nxt_ouflag)
                ctrl_ff <= (ctrl_wr_en ? ctrl_wr_data : ctrl_ff)
                         | (32'h1 << OUFLAG_BIT);
        end
    end

    // Registered result, one cycle after issue.
    // The data fields hold until the next accepted issue, which lets a slow
    // write-back stage pick them up late; only the valid pulse is one cycle.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            result_valid <= 1'b0;
            result <= '0;
        end
        else
        begin
            result_valid <= accept;
            if (accept)
            begin
                result.data <= nxt_data;
                result.dest <= nxt_dest;
                result.ouflag_set <= nxt_ouflag;
            end
        end
    end

    // Exceptions depend only on encoding and enable, never on operand values.
    // Both are single-cycle pulses lined up with where the result would have been,
    // so the pipeline sees exactly one answer per valid issue.
    // A reserved encoding wins over a disabled extension because it is not ours.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            exc_reserved <= 1'b0;
            exc_disabled <= 1'b0;
        end
        else
        begin
            exc_reserved <= issue_valid && (op == OP_NONE);
            exc_disabled <= issue_valid && (op != OP_NONE) && !ext_enabled;
        end
    end

endmodule // packed_add_halve_carry_unit

// ==== src/add_halve_pkg.sv ====
// Package with opcodes, field positions and types for the packed add/halve/carry unit.
package add_halve_pkg;
    // Instruction field positions.
    localparam int MAJOR_HI = 31;
    localparam int MAJOR_LO = 26;
    localparam int RS_HI = 25;
    localparam int RS_LO = 21;
    localparam int RT_HI = 20;
    localparam int RT_LO = 16;
    localparam int RD_HI = 15;
    localparam int RD_LO = 11;
    localparam int SUBOP_HI = 10;
    localparam int SUBOP_LO = 6;
    localparam int FUNC_HI = 5;
    localparam int FUNC_LO = 0;

    // Opcode values.
    localparam logic [5:0] OP_EXT_MAJOR = 6'h1f;
    localparam logic [5:0] FN_OCT = 6'h14;
    localparam logic [5:0] FN_QUAD = 6'h18;
    localparam logic [5:0] FN_WORD = 6'h10;
    localparam logic [5:0] FN_APPEND = 6'h31;
    localparam logic [4:0] SO_QH_ADD = 5'h08;
    localparam logic [4:0] SO_QH_SAT = 5'h0c;
    localparam logic [4:0] SO_OB_HALVE = 5'h18;
    localparam logic [4:0] SO_OB_HALVE_R = 5'h1a;
    localparam logic [4:0] SO_QB_HALVE = 5'h00;
    localparam logic [4:0] SO_QB_HALVE_R = 5'h02;
    localparam logic [4:0] SO_WORD_CARRY = 5'h11;
    localparam logic [4:0] SO_APPEND = 5'h00;

    // Control register layout and reset.
    localparam int CTRL_W = 32;
    localparam int OUFLAG_BIT = 20;
    localparam int CARRY_BIT = 13;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Decoded operation.
    typedef enum logic [3:0] {
        OP_NONE, OP_QH_ADD, OP_QH_SAT, OP_OB_HALVE, OP_OB_HALVE_R,
        OP_QB_HALVE, OP_QB_HALVE_R, OP_WORD_CARRY, OP_APPEND
    } op_e;

    // Issue bundle from the pipeline.
    typedef struct packed {
        logic [31:0] instr;
        logic [63:0] src_s;
        logic [63:0] src_t;
    } issue_s;

    // Result bundle back to the pipeline.
    typedef struct packed {
        logic [4:0] dest;
        logic [63:0] data;
        logic ouflag_set;
    } result_s;
endpackage

// ==== test/issue_encoder.sv ====
// Pipeline model that packs an instruction word with its operands.
`timescale 1ns/10ps
module issue_encoder
    import add_halve_pkg::*;
(
    // Instruction fields and operands.
    input wire logic [5:0] major,
    input wire logic [4:0] rd,
    input wire logic [4:0] sub,
    input wire logic [5:0] fn,
    input wire logic [63:0] s,
    input wire logic [63:0] t,
    // Bundle to the unit.
    output issue_s issue
);
    // The rs and rt numbers are fixed, so rt comes back as the append destination.
    assign issue = '{{major, 5'h01, 5'h07, rd, sub, fn}, s, t};
endmodule // issue_encoder

// ==== test/packed_add_halve_carry_unit_assertions.sv ====
// Checker for the packed add, halve, carry and append unit.
`timescale 1ns/10ps
module packed_add_halve_carry_unit_assertions
    import add_halve_pkg::*;
(
    // Clock, reset and inputs.
    input wire logic clk,
    input wire logic rst_n,
    input wire logic issue_valid,
    input wire issue_s issue,
    input wire logic ext_enabled,
    input wire logic ctrl_wr_en,
    // Outputs.
    input wire logic result_valid,
    input wire result_s result,
    input wire logic exc_reserved,
    input wire logic exc_disabled,
    input wire logic [31:0] dsp_control_reg
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Decoded fields; everything but the flag is gathered so one check covers it.
    logic go;
    logic [5:0] fn;
    logic [4:0] so;
    logic [30:0] rest;
    assign go = issue_valid && ext_enabled && issue.instr[31:26] == OP_EXT_MAJOR;
    assign fn = issue.instr[5:0];
    assign so = issue.instr[10:6];
    assign rest = {dsp_control_reg[31:21], dsp_control_reg[19:0]};

    property p_dis; issue_valid && !ext_enabled |=> exc_disabled && !result_valid; endproperty
    a_dis: assert property (p_dis) else $error("disabled issue not refused");
    property p_ans; issue_valid && ext_enabled |=> result_valid != exc_reserved; endproperty
    a_ans: assert property (p_ans) else $error("no single answer");
    property p_stk; dsp_control_reg[20] && !ctrl_wr_en |=> dsp_control_reg[20]; endproperty
    a_stk: assert property (p_stk) else $error("flag cleared");
    property p_kep; !ctrl_wr_en |=> $stable(rest); endproperty
    a_kep: assert property (p_kep) else $error("control field changed");
    property p_flg; result_valid && result.ouflag_set |-> dsp_control_reg[20]; endproperty
    a_flg: assert property (p_flg) else $error("flag not set");
    property p_hlv; go && (fn == FN_QUAD || fn == FN_OCT && so[4])
        |=> !(result_valid && result.ouflag_set); endproperty
    a_hlv: assert property (p_hlv) else $error("halve raised flag");
    property p_dst; go && fn == FN_APPEND && so == SO_APPEND
        |=> result.dest == $past(issue.instr[20:16]); endproperty
    a_dst: assert property (p_dst) else $error("append destination wrong");
    property p_sx; go && fn == FN_WORD && so == SO_WORD_CARRY
        |=> result.data[63:32] == {32{result.data[31]}}; endproperty
    a_sx: assert property (p_sx) else $error("word not sign extended");
endmodule // packed_add_halve_carry_unit_assertions

// ==== test/packed_add_halve_carry_unit_tb.sv ====
// Self-checking bench for the packed add, halve, carry and append unit.
`timescale 1ns/10ps
module packed_add_halve_carry_unit_tb;
    import add_halve_pkg::*;
    typedef struct packed {
        logic [4:0] sub;
        logic [5:0] fn;
        logic [4:0] rd;
        logic [63:0] s, t, q;
        logic f;
    } row_s;
    localparam int NR = 9;
    // Ordinary cases: operation, operands, then result and flag.
    row_s rows [NR] = '{
        '{SO_QH_ADD, FN_OCT, 5'h3, 64'hffff000180001234, 64'h1000180000001,
          64'h200001235, 1'h1},
        '{SO_QH_SAT, FN_OCT, 5'h3, 64'hffff000180001234, 64'h1000180000001,
          64'hffff0002ffff1235, 1'h1},
        '{SO_OB_HALVE, FN_OCT, 5'h4, 64'hff0102038000fe7f, 64'hff00020180010180,
          64'hff00020280007f7f, 1'h0},
        '{SO_OB_HALVE_R, FN_OCT, 5'h5, 64'hff0102038000fe7f, 64'hff00020180010180,
          64'hff01020280018080, 1'h0},
        '{SO_QB_HALVE_R, FN_QUAD, 5'h6, 64'hff0102038000fe7f, 64'hff00020180010180,
          64'hffffffff80018080, 1'h0},
        '{SO_WORD_CARRY, FN_WORD, 5'h8, 64'h123456787fffffff, 64'h1,
          64'hffffffff80000000, 1'h1},
        '{SO_APPEND, FN_APPEND, 5'h3, 64'h5, 64'h10000001, 64'hffffffff8000000d, 1'h0},
        '{SO_APPEND, FN_APPEND, 5'h0, 64'hffff, 64'hffffffff76543210, 64'h76543210, 1'h0},
        '{SO_QB_HALVE, FN_QUAD, 5'h9, 64'hffffffff017f0280, 64'h0000000001010280,
          64'h0000000001400280, 1'h0}};
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic issue_valid = 1'h0;
    logic ext_enabled = 1'h1;
    logic ctrl_wr_en = 1'h0;
    logic [31:0] ctrl_wr_data = 32'h0;
    logic [5:0] major = OP_EXT_MAJOR;
    logic [4:0] sub = 5'h0;
    logic [5:0] fn = 6'h0;
    logic [4:0] rd = 5'h3;
    logic [63:0] s = 64'h0;
    logic [63:0] t = 64'h0;
    issue_s issue;
    logic result_valid, exc_reserved, exc_disabled;
    result_s result;
    logic [31:0] dsp_control_reg;
    int mismatches = 0;
    int cmp_count = 0;

    always #2 clk = ~clk;
    // The pipeline model packs every issue.
    issue_encoder enc (.major(major), .rd(rd), .sub(sub), .fn(fn), .s(s), .t(t),
        .issue(issue));
    packed_add_halve_carry_unit uut (.clk(clk), .rst_n(rst_n), .issue_valid(issue_valid),
        .issue(issue), .ext_enabled(ext_enabled), .ctrl_wr_en(ctrl_wr_en),
        .ctrl_wr_data(ctrl_wr_data), .result_valid(result_valid), .result(result),
        .exc_reserved(exc_reserved), .exc_disabled(exc_disabled),
        .dsp_control_reg(dsp_control_reg));

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Inputs move one nanosecond after the edge so no race with sampling.
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic op(input logic [5:0] m, input logic [4:0] so, input logic [5:0] f,
        input logic [63:0] a, input logic [63:0] b);
        {major, sub, fn, s, t} = {m, so, f, a, b};
        issue_valid = 1'h1;
        tick();
        issue_valid = 1'h0;
    endtask
    task automatic final_report();
        $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // A hang costs a mismatch and ends the run.
    initial
    begin
        #20000;
        mismatches++;
        final_report();
    end

    initial
    begin
        repeat (3) tick();
        rst_n = 1'h1;
        chk({result_valid, exc_reserved, exc_disabled, dsp_control_reg}, 64'h0);
        // Rows go back to back; each answer is checked while the next issue stands.
        for (int i = 0; i <= NR; i++)
        begin
            issue_valid = (i < NR);
            if (i < NR)
                {sub, fn, rd, s, t} = {rows[i].sub, rows[i].fn, rows[i].rd, rows[i].s, rows[i].t};
            if (i > 0)
            begin
                chk(result_valid, 64'h1);
                chk(result.data, rows[i-1].q);
                chk(result.ouflag_set, rows[i-1].f);
                chk(result.dest, rows[i-1].fn == FN_APPEND ? 5'h7 : rows[i-1].rd);
            end
            tick();
        end
        chk(dsp_control_reg, 64'h100000);
        {ctrl_wr_en, ctrl_wr_data} = {1'h1, 32'h2000};
        tick();
        ctrl_wr_en = 1'h0;
        op(OP_EXT_MAJOR, SO_OB_HALVE_R, FN_OCT, '1, '1);
        chk({result.data, dsp_control_reg[20]}, {64'hffffffffffffffff, 1'h0});
        ext_enabled = 1'h0;
        op(OP_EXT_MAJOR, SO_WORD_CARRY, FN_WORD, 64'h7fffffff, 64'h1);
        chk({result_valid, exc_disabled, dsp_control_reg}, 64'h100002000);
        ext_enabled = 1'h1;
        op(6'h0, SO_WORD_CARRY, FN_WORD, 64'h7fffffff, 64'h1);
        chk({result_valid, exc_reserved, dsp_control_reg}, 64'h100002000);
        op(OP_EXT_MAJOR, 5'h1f, FN_OCT, 64'h0, 64'h0);
        chk({result_valid, exc_reserved}, 64'h1);
        // Carry alone pushes the largest positive word over the edge.
        op(OP_EXT_MAJOR, SO_WORD_CARRY, FN_WORD, 64'h7fffffff, 64'h0);
        chk(result.data, 64'hffffffff80000000);
        chk(dsp_control_reg, 64'h102000);
        // A software clear landing with an overflow must lose to the set.
        {ctrl_wr_en, ctrl_wr_data} = {1'h1, 32'h0};
        op(OP_EXT_MAJOR, SO_WORD_CARRY, FN_WORD, 64'h7fffffff, 64'h1);
        ctrl_wr_en = 1'h0;
        chk(dsp_control_reg, 64'h100000);
        chk(result.data, 64'hffffffff80000001);
        final_report();
    end
endmodule // packed_add_halve_carry_unit_tb

bind packed_add_halve_carry_unit packed_add_halve_carry_unit_assertions chk_i (
    .clk(clk), .rst_n(rst_n), .issue_valid(issue_valid), .issue(issue),
    .ext_enabled(ext_enabled), .ctrl_wr_en(ctrl_wr_en), .result_valid(result_valid),
    .result(result), .exc_reserved(exc_reserved), .exc_disabled(exc_disabled),
    .dsp_control_reg(dsp_control_reg));
